// File: acs_pkg.sv
// Overview of operation
// - Y and Z coarse registers show the upper eight bits of the latest samples.
// - Status bit 7 sets at power-up and soft reset; any register write except to the restart register clears it.
// - Status bit 6 shows the awake state; it reads 1 unless linked or loop mode.
// - Status bit 5 sets when the inactivity detector reports stillness or free fall.
// - Status bit 4 sets when the activity detector reports motion over threshold.
// - Status bit 3 sets when the FIFO overwrites a sample the host never read.
// - Status bit 2 is high while FIFO level is at or above the watermark.
// - Status bit 1 is high while at least one FIFO sample waits.
// - Status bit 0 sets on a new sample and clears on a FIFO read.
// - FIFO count 0 to 512 as ten bits: low byte, then two high bits.
// - Axis samples are 12-bit two's complement; high byte bits 15:12 copy bit 11.
// - Temperature uses the same split; top four bits match sign bit 11.
// - Writing the key to the restart register resets settings and enters standby.
// - After a soft reset the interrupt pin is released and keeps its level.
// - The restart register is write-only and reads as zero.
// - Hardware reset loads status with only the awake flag set; soft reset loads the awake flag and bit 7.
// - Chaining low bit 0 is default, 01 linked, 11 loop with internal acknowledge.
package acs_pkg;
	// ======================================================
	// Register map
	localparam logic [7:0] ACS_ADDR_Y_COARSE = 8'h09;
	localparam logic [7:0] ACS_ADDR_Z_COARSE = 8'h0a;
	localparam logic [7:0] ACS_ADDR_FLAGS = 8'h0b;
	localparam logic [7:0] ACS_ADDR_CNT_LO = 8'h0c;
	localparam logic [7:0] ACS_ADDR_CNT_HI = 8'h0d;
	localparam logic [7:0] ACS_ADDR_X_LO = 8'h0e;
	localparam logic [7:0] ACS_ADDR_X_HI = 8'h0f;
	localparam logic [7:0] ACS_ADDR_Y_LO = 8'h10;
	localparam logic [7:0] ACS_ADDR_Y_HI = 8'h11;
	localparam logic [7:0] ACS_ADDR_Z_LO = 8'h12;
	localparam logic [7:0] ACS_ADDR_Z_HI = 8'h13;
	localparam logic [7:0] ACS_ADDR_T_LO = 8'h14;
	localparam logic [7:0] ACS_ADDR_T_HI = 8'h15;
	localparam logic [7:0] ACS_ADDR_RESTART = 8'h1f;
	localparam logic [7:0] ACS_RESTART_KEY = 8'h52;
	localparam logic [7:0] ACS_READ_ZERO = 8'h00;
	// ======================================================
	// Status layout
	localparam int ACS_BIT_ERR = 7;
	localparam int ACS_BIT_AWAKE = 6;
	localparam int ACS_BIT_STILL = 5;
	localparam int ACS_BIT_MOTION = 4;
	localparam int ACS_BIT_OVR = 3;
	localparam int ACS_BIT_WMARK = 2;
	localparam int ACS_BIT_FREADY = 1;
	localparam int ACS_BIT_DREADY = 0;
	localparam logic [7:0] ACS_FLAGS_RESET = 8'h40;
	localparam int ACS_LINK_BIT = 0;
	localparam logic [1:0] ACS_LOOP_MODE = 2'h3;
	// ======================================================
	// Field widths
	localparam int ACS_BYTE_W = 8;
	localparam int ACS_SAMPLE_W = 12;
	localparam int ACS_HI_W = 4;
	localparam int ACS_CNT_W = 10;
	// ======================================================
	// Serial port
	localparam logic [7:0] ACS_CMD_WRITE = 8'h0a;
	localparam logic [7:0] ACS_CMD_READ = 8'h0b;
	localparam logic [2:0] ACS_BIT_FETCH = 3'h6;
	localparam logic [2:0] ACS_BIT_LAST = 3'h7;
	localparam logic [2:0] ACS_BIT_FIRST = 3'h0;
	typedef enum logic [1:0] {ACS_PH_CMD, ACS_PH_ADDR, ACS_PH_DATA} acs_phase_t;
endpackage

// File: acs_status_regs.sv
`timescale 1ns/1ps
module acs_status_regs import acs_pkg::*; (
	// System
	input wire logic clock,
	input wire logic rstn,
	// Serial register port
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	// Sample sources
	input wire logic sample_strobe,
	input wire logic [11:0] x_sample,
	input wire logic [11:0] y_sample,
	input wire logic [11:0] z_sample,
	input wire logic [11:0] temp_sample,
	// Detectors and FIFO
	input wire logic motion_event,
	input wire logic stillness_event,
	input wire logic awake_state,
	input wire logic [1:0] link_loop,
	input wire logic fifo_overrun_event,
	input wire logic [9:0] fifo_level,
	input wire logic [9:0] fifo_watermark,
	input wire logic fifo_read_done,
	// Interrupt pin
	input wire logic int_level,
	output logic int_pin,
	output logic int_pin_oe,
	// Writes to the rest of the device
	output logic reg_wr_strobe,
	output logic [7:0] reg_wr_addr,
	output logic [7:0] reg_wr_data,
	output logic soft_reset_pulse
);
	// ======================================================
	// Serial side, clocked by sclk
	acs_phase_t phase;
	logic [2:0] bit_cnt;
	logic [6:0] in_shift;
	logic [7:0] cmd;
	logic [7:0] addr_ptr;
	logic [7:0] out_shift;
	logic req_tgl;
	logic req_write;
	logic [7:0] req_addr;
	logic [7:0] req_data;
	logic [15:0] rdata_pair;

	wire [7:0] in_byte = {in_shift, mosi};
	wire byte_end = bit_cnt == ACS_BIT_LAST;
	wire is_read = cmd == ACS_CMD_READ;
	wire is_write = cmd == ACS_CMD_WRITE;
	wire [7:0] addr_next = addr_ptr + 8'h01;
	wire fetch_addr = phase == ACS_PH_ADDR && is_read;
	// Refetch only when a new pair starts, so status is acknowledged once
	wire pair_done = phase == ACS_PH_DATA && is_read && addr_ptr[0];
	wire fetch_now = bit_cnt == ACS_BIT_FETCH && (fetch_addr || pair_done);
	wire [6:0] fetch_prefix = phase == ACS_PH_ADDR ? {in_shift[5:0], mosi} : addr_next[7:1];
	wire write_now = byte_end && phase == ACS_PH_DATA && is_write;
	wire load_out = bit_cnt == ACS_BIT_FIRST && phase == ACS_PH_DATA && is_read;
	wire [7:0] sel_byte = addr_ptr[0] ? rdata_pair[15:8] : rdata_pair[7:0];

	// ======================================================
	// Frame state ends with the frame
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt <= ACS_BIT_FIRST;
			in_shift <= 7'h00;
			phase <= ACS_PH_CMD;
			cmd <= 8'h00;
			addr_ptr <= 8'h00;
		end else begin
			bit_cnt <= bit_cnt + 3'h1;
			in_shift <= in_byte[6:0];
			if (byte_end) begin
				case (phase)
					ACS_PH_CMD: begin
						cmd <= in_byte;
						phase <= ACS_PH_ADDR;
					end
					ACS_PH_ADDR: begin
						addr_ptr <= in_byte;
						phase <= ACS_PH_DATA;
					end
					ACS_PH_DATA: addr_ptr <= addr_next;
					default: phase <= ACS_PH_CMD;
				endcase
			end
		end
	end

	// ======================================================
	// Requests to the core; fields hold until the next toggle
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			req_tgl <= 1'b0;
			req_write <= 1'b0;
			req_addr <= 8'h00;
			req_data <= 8'h00;
		end else if (fetch_now || write_now) begin
			req_tgl <= ~req_tgl;
			req_write <= write_now;
			req_addr <= write_now ? addr_ptr : {fetch_prefix, 1'b0};
			req_data <= in_byte;
		end
	end

	// ======================================================
	// Read data shifts out on the falling edge
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			out_shift <= 8'h00;
			miso <= 1'b0;
			miso_oe <= 1'b0;
		end else if (load_out) begin
			out_shift <= {sel_byte[6:0], 1'b0};
			miso <= sel_byte[7];
			miso_oe <= 1'b1;
		end else begin
			out_shift <= {out_shift[6:0], 1'b0};
			miso <= out_shift[7];
		end
	end

	// ======================================================
	// Core side, clocked by clock
	logic req_s1;
	logic req_s2;
	logic req_s3;
	logic boot_done;
	logic err_f;
	logic awake_f;
	logic still_f;
	logic motion_f;
	logic ovr_f;
	logic wmark_f;
	logic fready_f;
	logic dready_f;
	logic [9:0] cnt;
	logic [11:0] x_val;
	logic [11:0] y_val;
	logic [11:0] z_val;
	logic [11:0] t_val;
	logic [7:0] flags;

	wire req_take = req_s2 ^ req_s3;
	wire wr_take = req_take && req_write;
	wire rd_take = req_take && !req_write;
	wire on_restart = req_addr == ACS_ADDR_RESTART;
	wire key_hit = wr_take && on_restart && req_data == ACS_RESTART_KEY;
	wire wr_effective = wr_take && !on_restart;
	wire status_fetch = rd_take && req_addr[7:1] == ACS_ADDR_FLAGS[7:1];
	wire linked = link_loop[ACS_LINK_BIT];
	wire loop = link_loop == ACS_LOOP_MODE;
	wire clr_motion = loop ? stillness_event : status_fetch;
	wire clr_still = loop ? motion_event : status_fetch;

	assign flags[ACS_BIT_ERR] = err_f;
	assign flags[ACS_BIT_AWAKE] = awake_f;
	assign flags[ACS_BIT_STILL] = still_f;
	assign flags[ACS_BIT_MOTION] = motion_f;
	assign flags[ACS_BIT_OVR] = ovr_f;
	assign flags[ACS_BIT_WMARK] = wmark_f;
	assign flags[ACS_BIT_FREADY] = fready_f;
	assign flags[ACS_BIT_DREADY] = dready_f;

	function automatic logic [7:0] lo_byte(input logic [11:0] v);
		lo_byte = v[ACS_BYTE_W-1:0];
	endfunction

	function automatic logic [7:0] hi_byte(input logic [11:0] v);
		hi_byte = {{ACS_HI_W{v[ACS_SAMPLE_W-1]}}, v[ACS_SAMPLE_W-1 -: ACS_HI_W]};
	endfunction

	function automatic logic [7:0] coarse(input logic [11:0] v);
		coarse = v[ACS_SAMPLE_W-1 -: ACS_BYTE_W];
	endfunction

	// ======================================================
	// Register contents as the host reads them
	wire [7:0] y_coarse_sample = coarse(y_val);
	wire [7:0] z_coarse_sample = coarse(z_val);
	wire [7:0] condition_flags = flags;
	wire [7:0] queue_count_low = cnt[ACS_BYTE_W-1:0];
	wire [7:0] queue_count_high = 8'(cnt >> ACS_BYTE_W);
	wire [7:0] x_sample_low = lo_byte(x_val);
	wire [7:0] x_sample_high = hi_byte(x_val);
	wire [7:0] y_sample_low = lo_byte(y_val);
	wire [7:0] y_sample_high = hi_byte(y_val);
	wire [7:0] z_sample_low = lo_byte(z_val);
	wire [7:0] z_sample_high = hi_byte(z_val);
	wire [7:0] thermal_sample_low = lo_byte(t_val);
	wire [7:0] thermal_sample_high = hi_byte(t_val);
	logic [7:0] fetch_odd;
	logic [7:0] fetch_even;

	// Both bytes of the fetched pair
	acs_reg_pick u_acs_reg_pick_odd (
		.addr({req_addr[7:1], 1'b1}),
		.y_coarse_sample(y_coarse_sample),
		.z_coarse_sample(z_coarse_sample),
		.condition_flags(condition_flags),
		.queue_count_low(queue_count_low),
		.queue_count_high(queue_count_high),
		.x_sample_low(x_sample_low),
		.x_sample_high(x_sample_high),
		.y_sample_low(y_sample_low),
		.y_sample_high(y_sample_high),
		.z_sample_low(z_sample_low),
		.z_sample_high(z_sample_high),
		.thermal_sample_low(thermal_sample_low),
		.thermal_sample_high(thermal_sample_high),
		.value(fetch_odd)
	);
	acs_reg_pick u_acs_reg_pick_even (
		.addr({req_addr[7:1], 1'b0}),
		.y_coarse_sample(y_coarse_sample),
		.z_coarse_sample(z_coarse_sample),
		.condition_flags(condition_flags),
		.queue_count_low(queue_count_low),
		.queue_count_high(queue_count_high),
		.x_sample_low(x_sample_low),
		.x_sample_high(x_sample_high),
		.y_sample_low(y_sample_low),
		.y_sample_high(y_sample_high),
		.z_sample_low(z_sample_low),
		.z_sample_high(z_sample_high),
		.thermal_sample_low(thermal_sample_low),
		.thermal_sample_high(thermal_sample_high),
		.value(fetch_even)
	);

	// ======================================================
	// Request toggle synchroniser
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end else begin
			req_s1 <= req_tgl;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	// ======================================================
	// Read pair and outgoing writes
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata_pair <= 16'h0000;
			reg_wr_strobe <= 1'b0;
			reg_wr_addr <= 8'h00;
			reg_wr_data <= 8'h00;
			soft_reset_pulse <= 1'b0;
		end else begin
			if (rd_take) begin
				rdata_pair <= {fetch_odd, fetch_even};
			end
			reg_wr_strobe <= wr_effective;
			reg_wr_addr <= req_addr;
			reg_wr_data <= req_data;
			soft_reset_pulse <= key_hit;
		end
	end

	// ======================================================
	// Samples, all four taken together
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			x_val <= 12'h000;
			y_val <= 12'h000;
			z_val <= 12'h000;
			t_val <= 12'h000;
		end else if (soft_reset_pulse) begin
			x_val <= 12'h000;
			y_val <= 12'h000;
			z_val <= 12'h000;
			t_val <= 12'h000;
		end else if (sample_strobe) begin
			x_val <= x_sample;
			y_val <= y_sample;
			z_val <= z_sample;
			t_val <= temp_sample;
		end
	end

	// ======================================================
	// Status flags; a set wins over a clear in the same cycle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			boot_done <= 1'b0;
			{err_f, awake_f, still_f, motion_f} <= ACS_FLAGS_RESET[7:4];
			{ovr_f, wmark_f, fready_f, dready_f} <= ACS_FLAGS_RESET[3:0];
			cnt <= 10'h000;
		end else if (soft_reset_pulse) begin
			boot_done <= 1'b1;
			{err_f, awake_f, still_f, motion_f} <= ACS_FLAGS_RESET[7:4];
			{ovr_f, wmark_f, fready_f, dready_f} <= ACS_FLAGS_RESET[3:0];
			err_f <= 1'b1;
			cnt <= 10'h000;
		end else begin
			boot_done <= 1'b1;
			err_f <= !boot_done || (err_f && !wr_effective);
			awake_f <= linked ? awake_state : 1'b1;
			still_f <= stillness_event || (still_f && !clr_still);
			motion_f <= motion_event || (motion_f && !clr_motion);
			ovr_f <= fifo_overrun_event || (ovr_f && !status_fetch);
			wmark_f <= fifo_level >= fifo_watermark;
			fready_f <= fifo_level != 10'h000;
			dready_f <= sample_strobe || (dready_f && !fifo_read_done);
			cnt <= fifo_level;
		end
	end

	// ======================================================
	// Interrupt pin, released on soft reset with its level kept
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			int_pin <= 1'b0;
			int_pin_oe <= 1'b0;
		end else begin
			if (soft_reset_pulse) begin
				int_pin_oe <= 1'b0;
			end else if (wr_effective) begin
				int_pin_oe <= 1'b1;
			end
			if (int_pin_oe && !soft_reset_pulse) begin
				int_pin <= int_level;
			end
		end
	end
endmodule // acs_status_regs

// ======================================================
// Register selection for one byte of a pair
module acs_reg_pick import acs_pkg::*; (
	// Byte address
	input wire logic [7:0] addr,
	// Register contents
	input wire logic [7:0] y_coarse_sample,
	input wire logic [7:0] z_coarse_sample,
	input wire logic [7:0] condition_flags,
	input wire logic [7:0] queue_count_low,
	input wire logic [7:0] queue_count_high,
	input wire logic [7:0] x_sample_low,
	input wire logic [7:0] x_sample_high,
	input wire logic [7:0] y_sample_low,
	input wire logic [7:0] y_sample_high,
	input wire logic [7:0] z_sample_low,
	input wire logic [7:0] z_sample_high,
	input wire logic [7:0] thermal_sample_low,
	input wire logic [7:0] thermal_sample_high,
	// Selected byte
	output logic [7:0] value
);
	always_comb begin
		case (addr)
			ACS_ADDR_Y_COARSE: value = y_coarse_sample;
			ACS_ADDR_Z_COARSE: value = z_coarse_sample;
			ACS_ADDR_FLAGS: value = condition_flags;
			ACS_ADDR_CNT_LO: value = queue_count_low;
			ACS_ADDR_CNT_HI: value = queue_count_high;
			ACS_ADDR_X_LO: value = x_sample_low;
			ACS_ADDR_X_HI: value = x_sample_high;
			ACS_ADDR_Y_LO: value = y_sample_low;
			ACS_ADDR_Y_HI: value = y_sample_high;
			ACS_ADDR_Z_LO: value = z_sample_low;
			ACS_ADDR_Z_HI: value = z_sample_high;
			ACS_ADDR_T_LO: value = thermal_sample_low;
			ACS_ADDR_T_HI: value = thermal_sample_high;
			default: value = ACS_READ_ZERO;
		endcase
	end
endmodule // acs_reg_pick

// File: acs_chk_checker.sv
`timescale 1ns/1ps
module acs_chk import acs_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Serial port
	input wire logic cs_n,
	input wire logic miso,
	input wire logic miso_oe,
	// Pin and writes
	input wire logic int_level,
	input wire logic int_pin,
	input wire logic int_pin_oe,
	input wire logic reg_wr_strobe,
	input wire logic [7:0] reg_wr_addr,
	input wire logic soft_reset_pulse
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// ====
	// Checks
	a_key_one_pulse: assert property (soft_reset_pulse |=> !soft_reset_pulse)
		else $error("restart pulse too long");
	a_key_not_passed: assert property (soft_reset_pulse |-> !reg_wr_strobe)
		else $error("restart write forwarded");
	a_restart_hidden: assert property (reg_wr_strobe |-> reg_wr_addr != ACS_ADDR_RESTART)
		else $error("restart address forwarded");
	a_write_one_pulse: assert property (reg_wr_strobe |=> !reg_wr_strobe)
		else $error("write strobe too long");
	a_pin_released: assert property (soft_reset_pulse |-> ##[0:2] !int_pin_oe)
		else $error("pin still driven");
	a_pin_kept: assert property (!int_pin_oe ##1 !int_pin_oe |-> $stable(int_pin))
		else $error("released pin moved");
	a_pin_follows: assert property (int_pin_oe ##1 int_pin_oe |-> int_pin == $past(int_level))
		else $error("pin level wrong");
	a_idle_quiet: assert property (cs_n ##1 cs_n |-> !miso_oe && !miso)
		else $error("output active outside frame");
endmodule // acs_chk

bind acs_status_regs acs_chk u_acs_chk (.clock(clock), .rstn(rstn), .cs_n(cs_n), .miso(miso),
	.miso_oe(miso_oe), .int_level(int_level), .int_pin(int_pin), .int_pin_oe(int_pin_oe),
	.reg_wr_strobe(reg_wr_strobe), .reg_wr_addr(reg_wr_addr),
	.soft_reset_pulse(soft_reset_pulse));

// File: acs_host.sv
`timescale 1ns/1ps
module acs_host import acs_pkg::*; (
	// Serial lines
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	logic [7:0] rd;
	event got;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		rd = 8'h00;
	end
	// ====
	// One byte, clock idles low
	task xb(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			mosi = b[i];
			#24 sclk = 1'b1;
			rd = {rd[6:0], miso};
			#24 sclk = 1'b0;
		end
	endtask
	// ====
	// Whole frame
	task fr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d, input int n);
		#3 cs_n = 1'b0;
		xb(c);
		xb(a);
		repeat (n) begin
			xb(d);
			if (c == ACS_CMD_READ) ->got;
		end
		#24 cs_n = 1'b1;
		mosi = ~mosi;
		#96;
	endtask
endmodule // acs_host

// File: tb.sv
`timescale 1ns/1ps
module tb import acs_pkg::*;;
	logic clock, rstn, ss, mo, st, ov, rdn, aw, il, sclk, cs_n, mosi, miso, mq, ip, ipo, srp;
	logic [11:0] smp[4];
	logic [1:0] ll;
	logic [9:0] lvl, wm;
	logic [31:0] e;
	logic [7:0] f, q[$];
	int n_fail, cmp_count, n_sr;
	logic ws;
	logic [7:0] wa, wd;
	logic [15:0] w, wq[$];
	acs_status_regs u_acs_status_regs (.clock(clock), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi), .miso(miso), .miso_oe(mq), .sample_strobe(ss), .x_sample(smp[0]),
		.y_sample(smp[1]), .z_sample(smp[2]), .temp_sample(smp[3]), .motion_event(mo),
		.stillness_event(st), .awake_state(aw), .link_loop(ll), .fifo_overrun_event(ov),
		.fifo_level(lvl), .fifo_watermark(wm), .fifo_read_done(rdn), .int_level(il),
		.int_pin(ip), .int_pin_oe(ipo), .reg_wr_strobe(ws), .reg_wr_addr(wa), .reg_wr_data(wd),
		.soft_reset_pulse(srp));
	acs_host u_acs_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	always #5 clock = ~clock;
	always @(negedge clock) if (srp) n_sr++;
	// ====
	// Checking
	task chk(input string s, input logic [7:0] x, input logic [7:0] g);
		cmp_count++;
		if (g !== x) begin
			n_fail++;
			$display("Error %s expected %h seen %h", s, x, g);
		end
	endtask
	always @(u_acs_host.got) chk("read", q.pop_front(), u_acs_host.rd);
	always @(negedge clock) begin
		if (ws) begin
			w = wq.pop_front();
			chk("write addr", w[15:8], wa);
			chk("write data", w[7:0], wd);
		end
	end
	task stop_test;
		$display("Compares %0d, errors %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task ev(input logic [4:0] m);
		@(posedge clock);
		{ss, mo, st, ov, rdn} <= m;
		@(posedge clock);
		{ss, mo, st, ov, rdn} <= 5'h00;
		repeat (3) @(posedge clock);
	endtask
	task blank(input logic [7:0] s);
		for (int a = 9; a < 22; a++) q.push_back(a == 11 ? s : 8'h00);
		u_acs_host.fr(ACS_CMD_READ, ACS_ADDR_Y_COARSE, 8'h00, 13);
	endtask
	initial begin
		#800us;
		n_fail++;
		stop_test;
	end
	// ====
	// Main sequence
	initial begin
		{clock, rstn, ss, mo, st, ov, rdn, aw, il, ll, lvl, wm} = '0;
		smp = '{default: 12'h000};
		wm = 10'h001;
		n_sr = $urandom(32'hdd64973b);
		n_sr = 0;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		repeat (3) @(posedge clock);
		blank(8'hc0);
		wq.push_back({8'h20, 8'h5a});
		u_acs_host.fr(ACS_CMD_WRITE, 8'h20, 8'h5a, 1);
		for (int i = 0; i < 4; i++) begin
			e = $urandom;
			@(posedge clock);
			ll <= 2'(i);
			aw <= e[8];
			il <= e[9];
			lvl <= i == 1 ? 10'h200 : i == 2 ? 10'h000 : 10'(e[25:16] % 513);
			wm <= e[31:22];
			foreach (smp[k]) smp[k] <= 12'($urandom);
			ev(5'h10);
			if (e[0]) ev(5'h08);
			if (e[1]) ev(5'h04);
			if (e[2]) ev(5'h02);
			if (e[3]) ev(5'h01);
			f = {1'b0, ll[0] ? aw : 1'b1, e[1], e[0] & !(e[1] & ll == 2'h3), e[2],
				lvl >= wm, lvl != 10'h000, !e[3]};
			q.push_back(smp[1][11:4]);
			q.push_back(smp[2][11:4]);
			q.push_back(f);
			q.push_back(lvl[7:0]);
			q.push_back({6'h00, lvl[9:8]});
			foreach (smp[k]) begin
				q.push_back(smp[k][7:0]);
				q.push_back({{4{smp[k][11]}}, smp[k][11:8]});
			end
			u_acs_host.fr(ACS_CMD_READ, ACS_ADDR_Y_COARSE, 8'h00, 13);
		end
		@(posedge clock);
		{lvl, wm, ll} <= {10'h000, 10'h001, 2'h0};
		u_acs_host.fr(ACS_CMD_WRITE, ACS_ADDR_RESTART, ACS_RESTART_KEY, 1);
		chk("restart", 8'h01, 8'(n_sr));
		chk("pin enable", 8'h00, {7'h00, ipo});
		#500us;
		u_acs_host.fr(ACS_CMD_WRITE, ACS_ADDR_RESTART, 8'h51, 1);
		chk("restart", 8'h01, 8'(n_sr));
		blank(8'hc0);
		q.push_back(ACS_READ_ZERO);
		q.push_back(8'h00);
		u_acs_host.fr(ACS_CMD_READ, ACS_ADDR_RESTART, 8'h00, 2);
		wq.push_back({8'h22, 8'h3c});
		u_acs_host.fr(ACS_CMD_WRITE, 8'h22, 8'h3c, 1);
		blank(8'h40);
		chk("writes left", 8'h00, 8'(wq.size()));
		chk("reads left", 8'h00, 8'(q.size()));
		stop_test;
	end
endmodule // tb
